// ===== hw/nand_write_engine.sv
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
// Contract
// RULE1 - Status write frame: opcode 1Fh/01h, address byte, data byte updates register.
// RULE2 - Only lock, range, top-bottom, wp gate, otp, first lock, ecc bits writable.
// RULE3 - Power up: range bits, top-bottom, ecc on set to one; rest zero.
// RULE4 - Opcode 06h framed by select sets write_latch_flag.
// RULE5 - Loads, program execute and erase accepted only while write_latch_flag is one.
// RULE6 - Opcode 04h framed by select clears write_latch_flag.
// RULE7 - Latch cleared at power up and when page read, program or erase finish.
// RULE8 - D8h plus 24-bit page address erases its whole 64-page block to FFh.
// RULE9 - Erase runs only if select rises right after the last address bit.
// RULE10 - Erase self-timed, busy meanwhile, status readable, latch cleared at end.
// RULE11 - Erase of a block inside the protected range is not performed.
// RULE12 - Load: 02h/84h, 16-bit column using column_index, then data bytes.
// RULE13 - Buffer holds 2,176 bytes; bytes beyond its end are dropped.
// RULE14 - Plain load fills unwritten bytes with FFh; random load keeps them.
// RULE15 - With ecc on, parity slots of extra area get computed values.
// RULE16 - Opcodes 32h/34h load like 02h/84h but data come on four lines.
// RULE17 - Quad instructions are refused while write_protect_pin_gate is one.
// RULE18 - 10h plus 24-bit page address writes the buffer into that page.
// RULE19 - Program self-timed with busy, then latch cleared; protected page skipped.
// RULE20 - Host programs pages of a block in ascending order only.
// RULE21 - Host never programs one plane's data into another plane.
// RULE22 - 13h plus page address loads page into buffer, busy meanwhile.
// RULE23 - Status read 0Fh/05h plus address byte is served at any time.
// RULE24 - A refused load, erase or program changes nothing and never sets busy.
module nand_write_engine
  import nand_seq_pkg::*;
#(
  parameter int ERASE_TIME_NS = 2000000,
  parameter int PROGRAM_TIME_NS = 250000,
  parameter int PAGE_LOAD_TIME_NS = 25000,
  parameter int ARRAY_PAGES = 128
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Serial link pins
  input wire logic spi_clk_i,
  input wire logic spi_select_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);

  localparam int ERASE_CYCLES =
    (ERASE_TIME_NS * CORE_CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int PROGRAM_CYCLES =
    (PROGRAM_TIME_NS * CORE_CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int PAGE_LOAD_CYCLES =
    (PAGE_LOAD_TIME_NS * CORE_CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int AP_BITS = $clog2(ARRAY_PAGES);
  localparam int TOTAL_BLOCKS = (1 << PAGE_BITS) / PAGES_PER_BLOCK;

  // Pin synchronisers; only the second stage is read
  logic [5:0] sync1_reg, sync2_reg;
  logic sclk_prev_reg, sel_prev_reg;
  logic sclk_s, sel_s, rise, fall, sel_fall, sel_rise;
  logic [3:0] io_s;

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      // Idle levels: link clock low, select high, lines high
      sync1_reg <= 6'h1F;
      sync2_reg <= 6'h1F;
      sclk_prev_reg <= 1'b0;
      sel_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= {spi_clk_i, spi_select_n_i, io_i};
      sync2_reg <= sync1_reg;
      sclk_prev_reg <= sync2_reg[5];
      sel_prev_reg <= sync2_reg[4];
    end
  end

  assign sclk_s = sync2_reg[5];
  assign sel_s = sync2_reg[4];
  assign io_s = sync2_reg[3:0];
  assign rise = sclk_s & ~sclk_prev_reg & ~sel_s;
  assign fall = ~sclk_s & sclk_prev_reg & ~sel_s;
  assign sel_fall = ~sel_s & sel_prev_reg;
  assign sel_rise = sel_s & ~sel_prev_reg;

  // Storage: page buffer and a small slice of the array
  logic [7:0] buf_mem [BUF_BYTES];
  logic [7:0] arr_mem [ARRAY_PAGES][BUF_BYTES];
  logic [BUF_BYTES-1:0] fill_ff_reg;
  logic [ARRAY_PAGES-1:0] erased_reg;

  // Frame state
  logic [7:0] shift_reg, shift_next, tx_reg, tx_next, in_byte;
  logic [2:0] bit_cnt_reg, bit_cnt_next, byte_idx_reg, byte_idx_next;
  logic [2:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0] rsr_sel_reg, rsr_sel_next;
  cmd_type cmd_reg, cmd_next, decoded;
  logic quad_reg, quad_next, out_act_reg, out_act_next;
  logic [23:0] addr_reg, addr_next;
  logic [11:0] col_reg, col_next;
  logic [3:0] io_out_reg, io_out_next, io_oe_reg, io_oe_next;
  logic wel_reg, wel_next;
  logic [7:0] sr1_reg, sr1_next, sr2_reg, sr2_next, sr3;
  logic quad_data, byte_done, addr_complete, start_blocked;
  logic load_we, fill_all;
  op_kind_type start_kind;

  // Operation engine state
  op_state_type op_state_reg, op_state_next;
  op_kind_type kind_reg, kind_next;
  logic [PAGE_BITS-1:0] op_page_reg, op_page_next;
  logic [11:0] copy_col_reg, copy_col_next;
  logic [31:0] timer_reg, timer_next;
  logic [31:0] ecc_acc_reg, ecc_acc_next;
  logic busy, op_done, prog_we, rd_we, erase_go;
  logic [7:0] prog_data, rd_data, copy_eff, ecc_byte;
  logic [11:0] ecc_rel;
  logic [AP_BITS-1:0] apage;

  // Avalon state
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [11:0] buf_index_reg, buf_index_next;

  function automatic logic [7:0] sr_pick(input logic [3:0] sel,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    logic [7:0] v;
    v = 8'h00;
    if (sel == SR1_SEL) v = a;
    else if (sel == SR2_SEL) v = b;
    else if (sel == SR3_SEL) v = c;
    return v;
  endfunction

  function automatic logic [7:0] ecc_byte_of(input logic [11:0] col);
    return ecc_acc_reg[{col[SECTOR_LSB +: 2], 3'b000} +: 8];
  endfunction

  function automatic logic is_protected(input logic [PAGE_BITS-1:0] page,
      input logic [7:0] sr1);
    int blk, range, cnt;
    blk = int'(page) / PAGES_PER_BLOCK;
    range = int'(sr1[SR1_RANGE_LSB +: 4]);
    cnt = (range == 0) ? 0 : (1 << (range - 1));
    if (cnt > TOTAL_BLOCKS) cnt = TOTAL_BLOCKS;
    if (sr1[SR1_TB_BIT]) return blk < cnt;
    return blk >= TOTAL_BLOCKS - cnt;
  endfunction

  function automatic cmd_type decode_opcode(input logic [7:0] op,
      input logic write_latch_flag, input logic bsy, input logic wp_gate);
    cmd_type c;
    c = CMD_IGNORE;
    case (op)
      OPC_RSR_A, OPC_RSR_B: c = CMD_RSR;
      OPC_WSR_A, OPC_WSR_B: c = CMD_WSR;
      OPC_WEN: c = CMD_WEN;
      OPC_WDIS: c = CMD_WDIS;
      OPC_ERASE: c = write_latch_flag ? CMD_ERASE : CMD_IGNORE; // [RULE5]
      OPC_LOAD, OPC_LOAD_RND: c = write_latch_flag ? CMD_LOAD : CMD_IGNORE; // [RULE5]
      OPC_QLOAD, OPC_QLOAD_RND: begin
        c = (write_latch_flag && !wp_gate) ? CMD_LOAD : CMD_IGNORE; // [RULE17] [RULE5]
      end
      OPC_PROG: c = write_latch_flag ? CMD_PROG : CMD_IGNORE; // [RULE5]
      OPC_PREAD: c = CMD_PREAD;
      default: c = CMD_IGNORE;
    endcase
    // A busy device still answers status reads
    if (bsy && c != CMD_RSR) c = CMD_IGNORE; // [RULE23] [RULE24]
    return c;
  endfunction

  assign busy = (op_state_reg != OP_IDLE);
  assign quad_data = quad_reg && (byte_idx_reg >= IDX_LOAD_DATA);
  assign in_byte = quad_data ? {shift_reg[3:0], io_s} // [RULE16]
                             : {shift_reg[6:0], io_s[0]};
  assign byte_done = rise && (quad_data ? bit_cnt_reg[0]
                                        : (bit_cnt_reg == BIT_LAST));
  assign decoded = decode_opcode(in_byte, wel_reg, busy,
                                 sr1_reg[SR1_WP_GATE_BIT]);
  assign addr_complete = (byte_idx_reg == IDX_ADDR_DONE) &&
                         (bit_cnt_reg == 3'h0);
  assign start_blocked = is_protected(addr_reg[PAGE_BITS-1:0], sr1_reg);

  always_comb begin
    sr3 = 8'h00;
    sr3[SR3_WEL_BIT] = wel_reg;
    sr3[SR3_BUSY_BIT] = busy; // [RULE10]
  end

  // Frame decoder and status registers
  always_comb begin
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    byte_idx_next = byte_idx_reg;
    cmd_next = cmd_reg;
    quad_next = quad_reg;
    addr_next = addr_reg;
    col_next = col_reg;
    tx_next = tx_reg;
    tx_cnt_next = tx_cnt_reg;
    rsr_sel_next = rsr_sel_reg;
    out_act_next = out_act_reg;
    io_out_next = io_out_reg;
    io_oe_next = io_oe_reg;
    wel_next = wel_reg;
    sr1_next = sr1_reg;
    sr2_next = sr2_reg;
    start_kind = KIND_NONE;
    load_we = 1'b0;
    fill_all = 1'b0;
    if (op_done) wel_next = 1'b0; // [RULE7] [RULE10] [RULE19]
    if (sel_fall) begin
      bit_cnt_next = 3'h0;
      byte_idx_next = IDX_OPCODE;
      cmd_next = CMD_NONE;
      quad_next = 1'b0;
    end else if (sel_rise) begin
      unique case (cmd_reg)
        CMD_WEN: wel_next = 1'b1; // [RULE4]
        CMD_WDIS: wel_next = 1'b0; // [RULE6]
        CMD_ERASE: begin
          // Any other select timing drops the erase
          if (addr_complete && !start_blocked) begin // [RULE9] [RULE11]
            start_kind = KIND_ERASE; // [RULE8]
          end
        end
        CMD_PROG: begin
          if (addr_complete && !start_blocked) begin // [RULE19]
            start_kind = KIND_PROGRAM; // [RULE18]
          end
        end
        CMD_PREAD: if (addr_complete) start_kind = KIND_READ; // [RULE22]
        default: start_kind = KIND_NONE;
      endcase
      cmd_next = CMD_NONE;
      quad_next = 1'b0;
      out_act_next = 1'b0;
      io_oe_next = 4'h0;
    end else begin
      if (rise) begin
        shift_next = in_byte;
        bit_cnt_next = byte_done ? 3'h0 : bit_cnt_reg + 3'h1;
      end
      if (byte_done) begin
        byte_idx_next = (byte_idx_reg == IDX_MAX) ? IDX_MAX
                                                  : byte_idx_reg + 3'h1;
        if (byte_idx_reg == IDX_OPCODE) begin
          cmd_next = decoded;
          if (decoded == CMD_LOAD) begin
            quad_next = (in_byte == OPC_QLOAD) ||
                        (in_byte == OPC_QLOAD_RND); // [RULE16]
            fill_all = (in_byte == OPC_LOAD) ||
                       (in_byte == OPC_QLOAD); // [RULE14]
          end
        end else begin
          addr_next = {addr_reg[15:0], in_byte};
          unique case (cmd_reg)
            CMD_WSR: begin
              if (byte_idx_reg == IDX_WSR_DATA) begin // [RULE1]
                if (addr_reg[7:4] == SR1_SEL) begin
                  sr1_next = (sr1_reg & ~SR1_WR_MASK) |
                             (in_byte & SR1_WR_MASK); // [RULE2]
                end
                if (addr_reg[7:4] == SR2_SEL) begin
                  sr2_next = (sr2_reg & ~SR2_WR_MASK) |
                             (in_byte & SR2_WR_MASK); // [RULE2]
                end
              end
            end
            CMD_RSR: begin
              if (byte_idx_reg == IDX_REG_ADDR) begin // [RULE23]
                rsr_sel_next = in_byte[7:4];
                tx_next = sr_pick(in_byte[7:4], sr1_reg, sr2_reg, sr3);
                tx_cnt_next = 3'h0;
                out_act_next = 1'b1;
              end
            end
            CMD_LOAD: begin
              if (byte_idx_reg == IDX_COL_LOW) begin
                col_next = {addr_reg[3:0], in_byte}; // [RULE12]
              end else if (byte_idx_reg >= IDX_LOAD_DATA &&
                           col_reg < BUF_BYTES) begin // [RULE13]
                load_we = 1'b1;
                col_next = col_reg + 12'h001;
              end
            end
            default: col_next = col_reg;
          endcase
        end
      end
      if (fall && out_act_reg) begin
        // Data changes on the falling edge, MSB first, repeating
        io_out_next = {2'b00, tx_reg[7], 1'b0};
        io_oe_next = 4'b0010;
        tx_cnt_next = tx_cnt_reg + 3'h1;
        tx_next = {tx_reg[6:0], tx_reg[7]};
        if (tx_cnt_reg == BIT_LAST) begin
          tx_next = sr_pick(rsr_sel_reg, sr1_reg, sr2_reg, sr3);
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      byte_idx_reg <= IDX_OPCODE;
      cmd_reg <= CMD_NONE;
      quad_reg <= 1'b0;
      addr_reg <= 24'h000000;
      col_reg <= 12'h000;
      tx_reg <= 8'h00;
      tx_cnt_reg <= 3'h0;
      rsr_sel_reg <= 4'h0;
      out_act_reg <= 1'b0;
      io_out_reg <= 4'h0;
      io_oe_reg <= 4'h0;
      wel_reg <= 1'b0; // [RULE7]
      sr1_reg <= SR1_RESET; // [RULE3]
      sr2_reg <= SR2_RESET; // [RULE3]
    end else begin
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      byte_idx_reg <= byte_idx_next;
      cmd_reg <= cmd_next;
      quad_reg <= quad_next;
      addr_reg <= addr_next;
      col_reg <= col_next;
      tx_reg <= tx_next;
      tx_cnt_reg <= tx_cnt_next;
      rsr_sel_reg <= rsr_sel_next;
      out_act_reg <= out_act_next;
      io_out_reg <= io_out_next;
      io_oe_reg <= io_oe_next;
      wel_reg <= wel_next;
      sr1_reg <= sr1_next;
      sr2_reg <= sr2_next;
    end
  end

  // Array operation engine: byte-wide copy (none for erase), then the timer runs out
  assign apage = op_page_reg[AP_BITS-1:0];
  assign copy_eff = fill_ff_reg[copy_col_reg] ? ERASED_BYTE
                                              : buf_mem[copy_col_reg];
  assign ecc_rel = copy_col_reg - ECC_AREA_BASE;
  assign ecc_byte = ecc_acc_reg[{ecc_rel[5:4], 3'b000} +: 8];
  assign rd_data = erased_reg[apage] ? ERASED_BYTE
                                     : arr_mem[apage][copy_col_reg];

  always_comb begin
    op_state_next = op_state_reg;
    kind_next = kind_reg;
    op_page_next = op_page_reg;
    copy_col_next = copy_col_reg;
    timer_next = (timer_reg == 32'h0) ? timer_reg : timer_reg - 32'h1;
    ecc_acc_next = ecc_acc_reg;
    op_done = 1'b0;
    prog_we = 1'b0;
    rd_we = 1'b0;
    erase_go = 1'b0;
    prog_data = copy_eff;
    unique case (op_state_reg)
      OP_IDLE: begin
        timer_next = 32'h0;
        if (start_kind != KIND_NONE) begin
          kind_next = start_kind;
          op_page_next = addr_reg[PAGE_BITS-1:0];
          copy_col_next = 12'h000;
          ecc_acc_next = 32'h0;
          op_state_next = OP_COPY;
          unique case (start_kind)
            KIND_ERASE: begin
              timer_next = 32'(ERASE_CYCLES - 1); // [RULE10]
              erase_go = 1'b1; // [RULE8]
              op_state_next = OP_WAIT;
            end
            KIND_PROGRAM: timer_next = 32'(PROGRAM_CYCLES - 1); // [RULE19]
            default: timer_next = 32'(PAGE_LOAD_CYCLES - 1); // [RULE22]
          endcase
        end
      end
      OP_COPY: begin
        if (kind_reg == KIND_PROGRAM) begin
          prog_we = 1'b1; // [RULE18]
          if (copy_col_reg < MAIN_BYTES) begin
            ecc_acc_next[{copy_col_reg[SECTOR_LSB +: 2], 3'b000} +: 8] =
              ecc_byte_of(copy_col_reg) ^ copy_eff; // [RULE15]
          end else if (sr2_reg[SR2_ECC_BIT] &&
                       copy_col_reg >= ECC_AREA_BASE &&
                       ecc_rel[ECC_PARITY_BIT]) begin
            prog_data = ecc_byte; // [RULE15]
          end
        end else begin
          rd_we = 1'b1; // [RULE22]
        end
        copy_col_next = copy_col_reg + 12'h001;
        if (copy_col_reg == BUF_LAST_COL) op_state_next = OP_WAIT;
      end
      OP_WAIT: begin
        if (timer_reg == 32'h0) begin
          op_done = 1'b1;
          op_state_next = OP_IDLE;
          kind_next = KIND_NONE;
        end
      end
      default: op_state_next = OP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      op_state_reg <= OP_IDLE;
      kind_reg <= KIND_NONE;
      op_page_reg <= '0;
      copy_col_reg <= 12'h000;
      timer_reg <= 32'h0;
      ecc_acc_reg <= 32'h0;
    end else begin
      op_state_reg <= op_state_next;
      kind_reg <= kind_next;
      op_page_reg <= op_page_next;
      copy_col_reg <= copy_col_next;
      timer_reg <= timer_next;
      ecc_acc_reg <= ecc_acc_next;
    end
  end

  // Memories; loads and array copies never overlap since loads need idle
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      fill_ff_reg <= '1;
      erased_reg <= '1;
    end else begin
      if (fill_all) fill_ff_reg <= '1; // [RULE14]
      if (load_we) begin
        buf_mem[col_reg] <= in_byte; // [RULE12]
        fill_ff_reg[col_reg] <= 1'b0;
      end
      if (rd_we) begin
        buf_mem[copy_col_reg] <= rd_data;
        fill_ff_reg[copy_col_reg] <= 1'b0;
      end
      if (prog_we) begin
        // Programming only clears bits of what the page already holds
        arr_mem[apage][copy_col_reg] <= prog_data & rd_data;
      end
      if (op_done && kind_reg == KIND_PROGRAM) erased_reg[apage] <= 1'b0;
      for (int i = 0; i < ARRAY_PAGES; i++) begin
        if (erase_go && (i / PAGES_PER_BLOCK) ==
            (int'(addr_reg[PAGE_BITS-1:0]) % ARRAY_PAGES) /
            PAGES_PER_BLOCK) begin
          erased_reg[i] <= 1'b1; // [RULE8]
        end
      end
    end
  end

  // Avalon-MM slave: one wait cycle, then a single low-wait cycle
  always_comb begin
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    buf_index_next = buf_index_reg;
    if ((avs_read_i || avs_write_i) && wait_reg) begin
      wait_next = 1'b0;
      unique case (avs_address_i)
        REG_STATUS_VIEW: rdata_next = {8'h00, sr1_reg, sr2_reg, sr3};
        REG_BUF_INDEX: rdata_next = {20'h00000, buf_index_reg};
        REG_BUF_BYTE: begin
          rdata_next = 32'h0;
          if (buf_index_reg < BUF_BYTES) begin
            rdata_next[7:0] = fill_ff_reg[buf_index_reg] ? ERASED_BYTE
                                           : buf_mem[buf_index_reg];
          end
        end
        default: rdata_next = 32'h0;
      endcase
    end
    if (avs_write_i && !wait_reg && avs_address_i == REG_BUF_INDEX) begin
      if (avs_byteenable_i[0]) buf_index_next[7:0] = avs_writedata_i[7:0];
      if (avs_byteenable_i[1]) begin
        buf_index_next[11:8] = avs_writedata_i[11:8];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
      buf_index_reg <= 12'h000;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      buf_index_reg <= buf_index_next;
    end
  end

  assign io_o = io_out_reg;
  assign io_oe_o = io_oe_reg;
  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;

endmodule

// ===== include/nand_seq_pkg.sv
package nand_seq_pkg;

  // Instruction codes
  localparam logic [7:0] OPC_WSR_A = 8'h1F;
  localparam logic [7:0] OPC_WSR_B = 8'h01;
  localparam logic [7:0] OPC_WEN = 8'h06;
  localparam logic [7:0] OPC_WDIS = 8'h04;
  localparam logic [7:0] OPC_ERASE = 8'hD8;
  localparam logic [7:0] OPC_LOAD = 8'h02;
  localparam logic [7:0] OPC_LOAD_RND = 8'h84;
  localparam logic [7:0] OPC_QLOAD = 8'h32;
  localparam logic [7:0] OPC_QLOAD_RND = 8'h34;
  localparam logic [7:0] OPC_PROG = 8'h10;
  localparam logic [7:0] OPC_PREAD = 8'h13;
  localparam logic [7:0] OPC_RSR_A = 8'h0F;
  localparam logic [7:0] OPC_RSR_B = 8'h05;

  // Page buffer and array geometry
  localparam int COL_BITS = 12;
  localparam int PAGE_BITS = 16;
  localparam int PAGES_PER_BLOCK = 64;
  localparam logic [11:0] BUF_BYTES = 12'h880;
  localparam logic [11:0] BUF_LAST_COL = 12'h87F;
  localparam logic [11:0] MAIN_BYTES = 12'h800;
  localparam logic [11:0] ECC_AREA_BASE = 12'h840;
  localparam int ECC_PARITY_BIT = 3;
  localparam int SECTOR_LSB = 9;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Frame byte positions
  localparam logic [2:0] IDX_OPCODE = 3'h0;
  localparam logic [2:0] IDX_REG_ADDR = 3'h1;
  localparam logic [2:0] IDX_WSR_DATA = 3'h2;
  localparam logic [2:0] IDX_COL_LOW = 3'h2;
  localparam logic [2:0] IDX_LOAD_DATA = 3'h3;
  localparam logic [2:0] IDX_ADDR_DONE = 3'h4;
  localparam logic [2:0] IDX_MAX = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Status registers: selected by the upper nibble of the address byte
  localparam logic [3:0] SR1_SEL = 4'hA;
  localparam logic [3:0] SR2_SEL = 4'hB;
  localparam logic [3:0] SR3_SEL = 4'hC;
  localparam logic [7:0] SR1_WR_MASK = 8'hFF;
  localparam logic [7:0] SR2_WR_MASK = 8'hF0;
  localparam logic [7:0] SR1_RESET = 8'h7C;
  localparam logic [7:0] SR2_RESET = 8'h10;
  localparam int SR1_RANGE_LSB = 3;
  localparam int SR1_TB_BIT = 2;
  localparam int SR1_WP_GATE_BIT = 1;
  localparam int SR2_ECC_BIT = 4;
  localparam int SR3_WEL_BIT = 1;
  localparam int SR3_BUSY_BIT = 0;

  // Avalon-MM register byte offsets
  localparam logic [3:0] REG_STATUS_VIEW = 4'h0;
  localparam logic [3:0] REG_BUF_INDEX = 4'h4;
  localparam logic [3:0] REG_BUF_BYTE = 4'h8;

  // Timing
  localparam int CORE_CLK_MHZ = 125;
  localparam int NS_PER_US = 1000;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_IGNORE, CMD_WSR, CMD_WEN, CMD_WDIS, CMD_ERASE,
    CMD_LOAD, CMD_PROG, CMD_PREAD, CMD_RSR
  } cmd_type;

  typedef enum logic [1:0] {OP_IDLE, OP_COPY, OP_WAIT} op_state_type;
  typedef enum logic [1:0] {
    KIND_NONE, KIND_ERASE, KIND_PROGRAM, KIND_READ
  } op_kind_type;

endpackage

// ===== sim/nand_write_engine_monitor.sv
`timescale 1ns/1ps
module nand_write_engine_monitor
  import nand_seq_pkg::*;
(
  // Watched ports
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic spi_select_n_i,
  input wire logic [3:0] io_oe_o,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence req_s;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  ans_once_a: assert property (req_s |=>
    !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bad answer");
  no_spont_a: assert property (!avs_read_i && !avs_write_i &&
    avs_waitrequest_o |=> avs_waitrequest_o) else $error("stray answer");
  ans_cause_a: assert property (!avs_waitrequest_o |->
    $past(avs_read_i || avs_write_i)) else $error("answer uncaused");
  rd_hold_a: assert property (avs_waitrequest_o |->
    $stable(avs_readdata_o)) else $error("read data moved");
  unmapped_rd_a: assert property (req_s and avs_read_i &&
    avs_address_i == 4'hC |-> ##2 avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  view_ro_a: assert property (req_s and avs_read_i &&
    avs_address_i == REG_STATUS_VIEW |-> ##2 avs_readdata_o[31:24] == 8'h00
    && avs_readdata_o[11:8] == 4'h0) else $error("fixed bits set");
  oe_idle_a: assert property (spi_select_n_i [*8] |-> !io_oe_o[1])
    else $error("driving while deselected");
  oe_unused_a: assert property (io_oe_o[0] == 1'b0 &&
    io_oe_o[3:2] == 2'b00) else $error("unused line driven");
endmodule
bind nand_write_engine nand_write_engine_monitor u_mon (.core_clk_i,
  .rst_b_i, .spi_select_n_i, .io_oe_o, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o);

// ===== sim/serial_nand_write_erase_read_cmds_test.sv
`timescale 1ns/1ps
module serial_nand_write_erase_read_cmds_test;
  import nand_seq_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] rdat;
  logic [7:0] rx;
  wire logic [31:0] avs_readdata_o;
  wire logic avs_waitrequest_o;
  wire logic [3:0] hio;
  wire logic [3:0] dio;
  wire logic [3:0] doe;
  wire logic sclk;
  wire logic seln;
  int failures = 0;
  int cmp_count = 0;
  always #4 core_clk_i = ~core_clk_i;
  spi_host_model u_host (.clk_o(sclk), .sel_n_o(seln), .io_o(hio),
    .do_i(doe[1] ? dio[1] : ~hio[1]));
  nand_write_engine #(.ERASE_TIME_NS(2000), .PROGRAM_TIME_NS(100),
    .PAGE_LOAD_TIME_NS(100)) u_dut (.core_clk_i, .rst_b_i,
    .spi_clk_i(sclk), .spi_select_n_i(seln),
    .io_i({hio[3:2], doe[1] ? dio[1] : hio[1], hio[0]}), .io_o(dio),
    .io_oe_o(doe), .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o,
    .avs_waitrequest_o);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] wd);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge core_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rdat = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic st(input logic [23:0] e);
    bus(1'b0, REG_STATUS_VIEW, 32'h0);
    chk(rdat, {8'h00, e});
  endtask
  task automatic bf(input logic [11:0] c, input logic [7:0] e);
    bus(1'b1, REG_BUF_INDEX, {20'h0, c});
    bus(1'b0, REG_BUF_BYTE, 32'h0);
    chk(rdat, {24'h0, e});
  endtask
  task automatic cmd(input logic [63:0] d, input int n);
    u_host.send(d, n, 99, rx);
  endtask
  task automatic idle();
    do begin
      bus(1'b0, REG_STATUS_VIEW, 32'h0);
    end while (rdat[0] !== 1'b0);
  endtask
  task automatic final_report();
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #700us;
    failures++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    st({SR1_RESET, SR2_RESET, 8'h00});
    bus(1'b0, 4'hC, 32'h0);
    cmd(8'h06, 8);
    st(24'h7C1002);
    u_host.send(24'h0FC000, 24, 99, rx);
    chk({24'h0, rx}, 32'h02);
    cmd(8'h04, 8);
    st(24'h7C1000);
    cmd(24'h1FA000, 24);
    cmd(24'h01B0FF, 24);
    st(24'h00F000);
    cmd(32'h020000AA, 32);
    bf(12'h000, 8'hFF);
    cmd(8'h06, 8);
    cmd(32'h84000056, 32);
    bf(12'h000, 8'h56);
    cmd(40'h0200051234, 40);
    bf(12'h000, 8'hFF);
    bf(12'h006, 8'h34);
    cmd(40'h84087F7788, 40);
    bf(12'h87F, 8'h77);
    bf(12'h000, 8'hFF);
    bf(12'h005, 8'h12);
    u_host.send(32'h320000A5, 32, 24, rx);
    bf(12'h000, 8'hA5);
    cmd(24'h1FA00E, 24);
    u_host.send(32'h340001C3, 32, 24, rx);
    bf(12'h001, 8'hFF);
    cmd(32'h10000000, 32);
    cmd(32'hD8000005, 32);
    st(24'h0EF002);
    cmd(24'h1FA000, 24);
    cmd(24'hD80000, 24);
    st(24'h00F002);
    cmd(32'h10000000, 32);
    st(24'h00F003);
    u_host.send(24'h05C000, 24, 99, rx);
    chk({24'h0, rx}, 32'h03);
    idle();
    st(24'h00F000);
    cmd(8'h06, 8);
    cmd(32'h02000000, 32);
    cmd(32'h13000000, 32);
    idle();
    st(24'h00F000);
    bf(12'h000, 8'hA5);
    bf(12'h848, 8'h5A);
    cmd(8'h06, 8);
    cmd(32'hD8000005, 32);
    st(24'h00F003);
    idle();
    st(24'h00F000);
    cmd(32'h13000000, 32);
    idle();
    bf(12'h000, 8'hFF);
    final_report();
  end
endmodule

// ===== sim/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  // Host side of the link
  output logic clk_o,
  output logic sel_n_o,
  output logic [3:0] io_o,
  input wire logic do_i
);
  initial begin
    clk_o = 1'b0;
    sel_n_o = 1'b1;
    io_o = 4'hA;
  end
  // Whole frames, select rises right after the last bit
  // Callers keep page order and plane
  task automatic send(input logic [63:0] d, input int n, input int q,
    output logic [7:0] rx);
    int i;
    i = n;
    rx = 8'h00;
    sel_n_o = 1'b0;
    #100;
    while (i > 0) begin
      if (n - i >= q) begin
        io_o = d[i-1 -: 4];
        i = i - 4;
      end else begin
        io_o[0] = d[i-1];
        i = i - 1;
      end
      #62.5 clk_o = 1'b1;
      rx = {rx[6:0], do_i};
      #62.5 clk_o = 1'b0;
    end
    #100 sel_n_o = 1'b1;
    io_o = ~io_o;
    #500;
  endtask
endmodule
